// File: hdl/phy_led_config.sv
// Purpose: APB register slave choosing LED sources and holding crossover control
// Assumes: APB master per protocol; status inputs synchronous to clk_sys
// Notes: Zero wait states; read data is captured in the setup cycle
//
// Chosen here: the APB register port.
`include "phy_led_defines.svh"
module phy_led_config #(
  parameter int unsigned BLINK_HALF_CYCLES = `BLINK_HALF_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic linkGood,
  input wire logic activity,
  input wire logic speed100,
  input wire logic speed10,
  input wire logic fullDuplex,
  output logic firstLed,
  output logic secondLed,
  output logic [15:0] crossoverControl
);
  localparam logic [15:0] LED_RESET = `LED_CFG_RESET;
  localparam logic [11:0] LED_ADDR = `LED_CFG_ADDR;
  localparam logic [11:0] XOVER_ADDR = `XOVER_ADDR;

  // Only the two source fields are stored; reserved bits have no flops
  logic [`SECOND_SRC_MSB:0] ledSources;
  phy_led_pkg::reg16_t next_ledCfg;
  phy_led_pkg::reg16_t next_crossover;

  function automatic phy_led_pkg::reg16_t mergeLanes(
    input phy_led_pkg::reg16_t old,
    input logic [15:0] wdata,
    input logic [1:0] strb
  );
    mergeLanes = old;
    if (strb[0])
      mergeLanes[7:0] = wdata[7:0];
    if (strb[1])
      mergeLanes[15:8] = wdata[15:8];
  endfunction : mergeLanes

  wire setupPhase = psel & ~penable;
  wire accessPhase = psel & penable;
  wire hitLed = (paddr == LED_ADDR);
  wire hitXover = (paddr == XOVER_ADDR);
  wire mapped = hitLed | hitXover;
  wire writeLed = accessPhase & pwrite & hitLed;
  wire writeXover = accessPhase & pwrite & hitXover;
  wire [15:0] ledCfgView = {8'h00, ledSources}; // RQ6
  wire [31:0] readValue = hitLed ? {16'h0000, ledCfgView} :
                          hitXover ? {16'h0000, crossoverControl} : 32'h0000_0000;

  assign pready = accessPhase;
  assign pslverr = accessPhase & ~mapped;
  assign next_ledCfg = mergeLanes(ledCfgView, pwdata[15:0], pstrb[1:0]);
  assign next_crossover = mergeLanes(crossoverControl, pwdata[15:0], pstrb[1:0]);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ledSources <= LED_RESET[`SECOND_SRC_MSB:0]; // RQ1 RQ5 RQ7
      crossoverControl <= `XOVER_RESET; // RQ8
      prdata <= 32'h0000_0000;
    end
    else
    begin
      if (writeLed)
        ledSources <= next_ledCfg[`SECOND_SRC_MSB:0]; // RQ7
      if (writeXover)
        crossoverControl <= next_crossover; // RQ8
      if (setupPhase & ~pwrite)
        prdata <= readValue;
    end
  end

  phy_status_if status ();
  assign status.linkGood = linkGood;
  assign status.activity = activity;
  assign status.speed100 = speed100;
  assign status.speed10 = speed10;
  assign status.fullDuplex = fullDuplex;

  led_source_mux #(
    .BLINK_HALF(BLINK_HALF_CYCLES)
  ) firstMux (
    .clk_sys(clk_sys),
    .rst(rst),
    .status(status),
    .code(ledSources[`FIRST_SRC_MSB:`FIRST_SRC_LSB]), // RQ5
    .led(firstLed)
  );

  led_source_mux #(
    .BLINK_HALF(BLINK_HALF_CYCLES)
  ) secondMux (
    .clk_sys(clk_sys),
    .rst(rst),
    .status(status),
    .code(ledSources[`SECOND_SRC_MSB:`SECOND_SRC_LSB]), // RQ1
    .led(secondLed)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence ledReadSetup;
    psel && !penable && !pwrite && paddr == LED_ADDR;
  endsequence

  sequence accessDone;
    psel && penable && pready;
  endsequence

  sequence ledWrite;
    psel && penable && pwrite && paddr == LED_ADDR && pstrb[0];
  endsequence

  reset_value_a: assert property (disable iff (1'b0) rst |=> ledSources == 8'h10) // RQ7
    else $error("LED configuration reset value wrong");
  second_reset_a: assert property (disable iff (1'b0) rst |=> ledSources[7:4] == 4'h1) // RQ1
    else $error("Second LED source reset wrong");
  first_reset_a: assert property (disable iff (1'b0) rst |=> ledSources[3:0] == 4'h0) // RQ5
    else $error("First LED source reset wrong");
  xover_reset_a: assert property (disable iff (1'b0) rst |=> crossoverControl == 16'h00c0) // RQ8
    else $error("Crossover reset value wrong");
  led_write_a: assert property (ledWrite |=> ledSources == $past(pwdata[7:0])) // RQ7
    else $error("LED configuration write lost");
  reserved_read_a: assert property (ledReadSetup ##1 accessDone |-> prdata[31:8] == 24'h000000) // RQ6
    else $error("Reserved LED bits read nonzero");
  led_readback_a: assert property (ledReadSetup ##1 accessDone |-> prdata[7:0] == ledSources) // RQ7
    else $error("LED configuration readback wrong");
  xover_write_a: assert property (psel && penable && pwrite && paddr == XOVER_ADDR && pstrb == 4'hf
    |=> crossoverControl == $past(pwdata[15:0])) // RQ8
    else $error("Crossover write lost");
  unmapped_error_a: assert property (psel && penable && !mapped |-> pslverr && pready)
    else $error("Unmapped access not flagged");
endmodule : phy_led_config

// File: hdl/phy_led_defines.svh
// Purpose: Constants for the PHY LED source select block
// Assumes: 40 MHz clk_sys, APB with 32-bit data
// Notes: Register byte address is four times the management index
//
// Behaviour
// (RQ1) Bits 7:4 pick the second LED source; reset value 0x1.
// (RQ2) Code 0x0 shows link good; code 0x1 shows receive or transmit activity.
// (RQ3) Codes 0x5, 0x6, 0x7 show 100 Mb/s, 10 Mb/s, full duplex.
// (RQ4) Code 0x8 lights on link good and blinks on activity.
// (RQ5) Bits 3:0 pick the first LED source, same codes; reset value 0x0.
// (RQ6) Bits 15:8 are reserved, read-only, read as zero.
// (RQ7) LED configuration register at index 0x17, read/write, reset 0x0010.
// (RQ8) Crossover control register at index 0x18, read/write, reset 0x00c0.
// (RQ9) Reserved codes 0x2-0x4 and above 0x8 hold the LED dark.
`ifndef PHY_LED_DEFINES_SVH
`define PHY_LED_DEFINES_SVH

`define LED_CFG_INDEX 8'h17
`define XOVER_INDEX 8'h18
`define LED_CFG_ADDR ({4'h0, `LED_CFG_INDEX} << 2)
`define XOVER_ADDR ({4'h0, `XOVER_INDEX} << 2)
`define LED_CFG_RESET 16'h0010
`define XOVER_RESET 16'h00c0
`define SECOND_SRC_MSB 7
`define SECOND_SRC_LSB 4
`define FIRST_SRC_MSB 3
`define FIRST_SRC_LSB 0
`define RSVD_MSB 15
`define RSVD_LSB 8
`define CLK_HZ 40000000
`define BLINK_HALF_MS 50
`define BLINK_HALF_CYCLES ((`CLK_HZ / 1000) * `BLINK_HALF_MS)

`endif

// File: hdl/phy_led_pkg.sv
// Purpose: Types for the PHY LED source select block
// Assumes: Nothing
// Notes: Codes absent from the enum are reserved
package phy_led_pkg;
  typedef logic [3:0] led_code_t;
  typedef logic [15:0] reg16_t;
  typedef enum logic [3:0] {
    LINK_OK = 4'h0,
    ACTIVITY = 4'h1,
    SPEED_100 = 4'h5,
    SPEED_10 = 4'h6,
    FULL_DUPLEX = 4'h7,
    LINK_BLINK = 4'h8
  } led_source_t;
endpackage : phy_led_pkg

// File: hdl/phy_status_if.sv
// Purpose: PHY status conditions carried to each LED selector
// Assumes: All signals synchronous to clk_sys
// Notes: Levels, active high
interface phy_status_if;
  logic linkGood;
  logic activity;
  logic speed100;
  logic speed10;
  logic fullDuplex;
  modport source (output linkGood, output activity, output speed100, output speed10, output fullDuplex);
  modport sink (input linkGood, input activity, input speed100, input speed10, input fullDuplex);
endinterface : phy_status_if

// File: hdl/led_source_mux.sv
// Purpose: Drives one LED from the status condition its code selects
// Assumes: Status levels synchronous to clk_sys
// Notes: Blink phase runs free, so blinking starts in an arbitrary phase
`include "phy_led_defines.svh"
module led_source_mux #(
  parameter int unsigned BLINK_HALF = `BLINK_HALF_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  phy_status_if.sink status,
  input wire phy_led_pkg::led_code_t code,
  output logic led
);
  localparam int CW = $clog2(BLINK_HALF + 1);
  logic [CW-1:0] blinkCount;
  logic blinkPhase;
  logic next_led;
  wire blinkWrap = (blinkCount == CW'(BLINK_HALF - 1));

  always_comb
  begin
    case (code)
      phy_led_pkg::LINK_OK: next_led = status.linkGood; // RQ2
      phy_led_pkg::ACTIVITY: next_led = status.activity; // RQ2
      phy_led_pkg::SPEED_100: next_led = status.speed100; // RQ3
      phy_led_pkg::SPEED_10: next_led = status.speed10; // RQ3
      phy_led_pkg::FULL_DUPLEX: next_led = status.fullDuplex; // RQ3
      phy_led_pkg::LINK_BLINK: next_led = status.linkGood & ~(status.activity & blinkPhase); // RQ4
      default: next_led = 1'b0; // RQ9
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      blinkCount <= '0;
      blinkPhase <= 1'b0;
      led <= 1'b0;
    end
    else
    begin
      blinkCount <= blinkWrap ? '0 : blinkCount + 1'b1;
      blinkPhase <= blinkPhase ^ blinkWrap; // RQ4
      led <= next_led;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  link_source_a: assert property (code == 4'h0 |=> led == $past(status.linkGood)) // RQ2
    else $error("LED does not follow link good");
  activity_source_a: assert property (code == 4'h1 |=> led == $past(status.activity)) // RQ2
    else $error("LED does not follow activity");
  speed_source_a: assert property (code == 4'h5 && status.speed100 && !status.speed10 |=> led) // RQ3
    else $error("LED dark in 100 Mb/s mode");
  duplex_source_a: assert property (code == 4'h7 |=> led == $past(status.fullDuplex)) // RQ3
    else $error("LED does not follow full duplex");
  blink_dark_a: assert property (code == 4'h8 && !status.linkGood |=> !led) // RQ4
    else $error("Blink LED lit without link");
  blink_toggle_a: assert property (blinkWrap |=> blinkPhase != $past(blinkPhase)) // RQ4
    else $error("Blink phase did not toggle");
  reserved_dark_a: assert property ((code inside {4'h2, 4'h3, 4'h4} || code > 4'h8) |=> !led) // RQ9
    else $error("Reserved code lit the LED");
endmodule : led_source_mux

// File: testbench/led_board.sv
// Purpose: Board LED model, counting changes of the first LED
// Assumes: LED high means lit
// Notes: Counts only; the bench judges the blink rate
module led_board
(
  input wire logic clk_sys,
  input wire logic firstLed,
  output int firstFlips
);
  timeunit 1ns;
  timeprecision 100ps;
  // One process owns the count, so the output port has a single driver
  int flipCount = 0;
  logic last = 1'b0;
  assign firstFlips = flipCount;
  always @(posedge clk_sys)
  begin
    if (firstLed !== last)
      flipCount <= flipCount + 1;
    last <= firstLed;
  end
endmodule : led_board

// File: testbench/tb_phy_led_source_select.sv
// Purpose: Self-checking bench for the LED source select block
// Assumes: Blink half period shortened to 8 cycles
// Notes: Status levels are random from a fixed seed
module tb_phy_led_source_select;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [4:0] st = 5'h00;
  logic [31:0] prdata, rd, mX, mCfg, f0;
  logic pready, pslverr, err, firstLed, secondLed;
  logic [15:0] crossoverControl;
  int miscompares = 0;
  int n_tests = 0;
  int seed = 34868;
  int flips;
  phy_led_config #(.BLINK_HALF_CYCLES(8)) dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .linkGood(st[4]), .activity(st[3]), .speed100(st[2]),
    .speed10(st[1]), .fullDuplex(st[0]), .firstLed(firstLed), .secondLed(secondLed),
    .crossoverControl(crossoverControl));
  led_board board_u (.clk_sys(clk_sys), .firstLed(firstLed), .firstFlips(flips));
  initial forever #12.5 clk_sys = ~clk_sys;
  task automatic conclude;
    if (miscompares == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Holds the request until pready is seen; bounded so a dead slave ends the run
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk_sys);
      i++;
    end
    while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1)
    begin
      miscompares++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Reference LED function; status bits: link, activity, 100, 10, duplex
  function automatic logic expLed(input int c, input logic [4:0] s);
    case (c)
      0: return s[4];
      1: return s[3];
      5: return s[2];
      6: return s[1];
      7: return s[0];
      8: return s[4] & ~s[3];
      default: return 1'b0;
    endcase
  endfunction : expLed
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, 12'h05c, 32'h0, 4'hf);
    chk("cfg reset", 32'h10, rd);
    chk("cfg err", 32'h0, {31'h0, err});
    apb(1'b0, 12'h060, 32'h0, 4'hf);
    chk("xover reset", 32'hc0, rd);
    mX = $random(seed);
    apb(1'b1, 12'h060, mX, 4'hf);
    apb(1'b1, 12'h060, ~mX, 4'h0);
    apb(1'b0, 12'h060, 32'h0, 4'hf);
    chk("xover", mX & 32'hffff, rd);
    chk("xover port", {16'h0, mX[15:0]}, {16'h0, crossoverControl});
    apb(1'b1, 12'h064, 32'hffff, 4'hf);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b0, 12'h064, 32'h0, 4'hf);
    chk("unmapped rd", 32'h0, rd);
    chk("unmapped rd err", 32'h1, {31'h0, err});
    for (int c = 0; c < 16; c++)
    begin
      mCfg = c + 16 * (15 - c);
      // Upper bits random: reserved bits must come back zero
      f0 = $random(seed);
      apb(1'b1, 12'h05c, (f0 & 32'hffffff00) | mCfg, 4'hf);
      apb(1'b0, 12'h05c, 32'h0, 4'hf);
      chk("cfg", mCfg, rd);
      repeat (4)
      begin
        f0 = $random(seed);
        // Blink phase is free-running, so activity stays low under code 8
        if (c == 7 || c == 8)
          f0[3] = 1'b0;
        // Status changes only on a rising edge, never at the check point
        @(posedge clk_sys);
        st <= f0[4:0];
        repeat (2) @(posedge clk_sys);
        #1;
        chk("firstLed", {31'h0, expLed(c, st)}, {31'h0, firstLed});
        chk("secondLed", {31'h0, expLed(15 - c, st)}, {31'h0, secondLed});
      end
    end
    apb(1'b1, 12'h05c, 32'h08, 4'hf);
    st <= 5'h18;
    repeat (3) @(posedge clk_sys);
    f0 = flips;
    repeat (40) @(posedge clk_sys);
    chk("blinks", 32'h5, flips - f0);
    st <= 5'h08;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("blink no link", 32'h0, {31'h0, firstLed});
    // Mid-run reset must bring both registers back to their reset values
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("led reset", 32'h0, {31'h0, secondLed});
    @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, 12'h05c, 32'h0, 4'hf);
    chk("cfg rerun reset", 32'h10, rd);
    apb(1'b0, 12'h060, 32'h0, 4'hf);
    chk("xover rerun reset", 32'hc0, rd);
    #1;
    chk("firstLed reset src", {31'h0, expLed(0, st)}, {31'h0, firstLed});
    chk("secondLed reset src", {31'h0, expLed(1, st)}, {31'h0, secondLed});
    conclude();
  end
endmodule : tb_phy_led_source_select
